// >>> logic/olrc_params.svh
// Constants of the open-load response configuration block
`ifndef OLRC_PARAMS_SVH
`define OLRC_PARAMS_SVH

// ==========================================================
// Register map
`define OLRC_CFG_OFFSET      8'h23
`define OLRC_CFG_RESET       8'h00
`define OLRC_RDATA_UNMAPPED  8'h00

// ==========================================================
// Field positions inside the response select field
`define OLRC_RESP_OUTAGE_BIT 1
`define OLRC_RESP_DRIVE_BIT  0

// ==========================================================
// Slave address
`define OLRC_ADDR_PREFIX     2'h1
`define OLRC_FRESH_ADDR      7'h20

// ==========================================================
// Channels
`define OLRC_NUM_CH          12
`define OLRC_CH_ALL_ON       12'hfff
`define OLRC_CH_ALL_OFF      12'h000

`endif

// >>> logic/olrc_pkg.sv
// Types shared by the open-load response configuration block
`include "olrc_params.svh"

package olrc_pkg;

    // ==========================================================
    // Configuration byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic       parity_en;
        logic [1:0] resp_sel;
        logic [4:0] bus_addr;
    } olrc_cfg_t;

    // ==========================================================
    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } olrc_reg_req_t;

    // ==========================================================
    // Per-channel output control
    typedef struct packed {
        logic [`OLRC_NUM_CH-1:0] keep;
        logic [`OLRC_NUM_CH-1:0] recovery;
    } olrc_chan_t;

    // ==========================================================
    // Response state, one-hot
    typedef enum logic [2:0] {
        ST_NORMAL   = 3'h1,
        ST_RECOVER  = 3'h2,
        ST_SHUTDOWN = 3'h4
    } olrc_state_t;

endpackage

// >>> logic/olrc_chan_gate.sv
// Per-channel output gating for the open-load response
`timescale 1ns/1ns
`include "olrc_params.svh"

module olrc_chan_gate
    import olrc_pkg::*;
(
    // Response state
    input  wire olrc_state_t             state,
    // Diagnosis results
    input  wire logic [`OLRC_NUM_CH-1:0] open_fault,
    // Next channel control
    output olrc_chan_t                   nxt_chan
);

    // ==========================================================
    // Channel gating
    genvar i;
    generate
        for (i = 0; i < `OLRC_NUM_CH; i = i + 1) begin : g_ch
            always_comb begin
                nxt_chan.keep[i]     = 1'b1;
                nxt_chan.recovery[i] = 1'b0;
                unique case (state)
                    ST_NORMAL: begin
                        nxt_chan.keep[i]     = 1'b1;
                        nxt_chan.recovery[i] = 1'b0;
                    end
                    ST_RECOVER: begin
                        // Faulty branch keeps current, the rest go off
                        nxt_chan.keep[i]     = open_fault[i]; // RULE6
                        nxt_chan.recovery[i] = open_fault[i]; // RULE6
                    end
                    ST_SHUTDOWN: begin
                        nxt_chan.keep[i]     = 1'b0; // RULE8
                        nxt_chan.recovery[i] = 1'b0;
                    end
                    default: begin
                        nxt_chan.keep[i]     = 1'b0;
                        nxt_chan.recovery[i] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

endmodule

// >>> logic/olrc_top.sv
// Open-load diagnosis response, fault flag and slave address configuration
//
// What this block does
// RULE1 - Config byte at 0x23, read/write, resets 0x00
// RULE2 - Bit 7 enables bus parity check
// RULE3 - Upper select bit 0: recovery, lower drives flag
// RULE4 - Upper select bit 1: outage, lower drives flag
// RULE5 - Recovery diagnoses only while power good
// RULE6 - Recovery keeps faulty branch, others off
// RULE7 - Fault gone: outputs return to normal
// RULE8 - External flag in recovery: off, low power
// RULE9 - Power good low in recovery: ignore flag and diagnosis
// RULE10 - Outage diagnoses, regulation stays unchanged
// RULE11 - Outage ignores external flag assertion
// RULE12 - Slave address is 01 plus five bits
// RULE13 - Unprogrammed device answers address 0100000
// RULE14 - Driven modes pull flag low on fault
`timescale 1ns/1ns
`include "olrc_params.svh"

module olrc_top
    import olrc_pkg::*;
(
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire olrc_reg_req_t           reg_req,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_rvalid,
    output logic                         reg_hit,
    // Bus address check
    input  wire logic [6:0]              addr_probe,
    input  wire logic                    addr_probe_valid,
    output logic [6:0]                   slave_addr,
    output logic                         addr_match,
    output logic                         bus_parity_check_enable,
    // Diagnosis and supply
    input  wire logic                    power_good_input,
    input  wire logic [`OLRC_NUM_CH-1:0] open_fault,
    output logic                         diag_active,
    // Fault flag pin, open drain, asserted low
    input  wire logic                    fault_flag_line_in,
    output logic                         fault_flag_line_out,
    output logic                         fault_flag_line_oe_n,
    // Output stage control
    output olrc_chan_t                   chan_ctrl,
    output logic                         low_power_mode
);

    // ==========================================================
    // Configuration register
    olrc_cfg_t  cfg_ff;
    olrc_cfg_t  nxt_cfg;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       rvalid_ff;
    logic       nxt_rvalid;
    logic       programmed_ff;
    logic       nxt_programmed;
    logic       cfg_sel;

    assign cfg_sel = (reg_req.addr == `OLRC_CFG_OFFSET);
    assign reg_hit = cfg_sel & (reg_req.wr | reg_req.rd);

    always_comb begin
        nxt_cfg        = cfg_ff;
        nxt_programmed = programmed_ff;
        nxt_rdata      = rdata_ff;
        nxt_rvalid     = reg_req.rd;
        if (reg_req.wr && cfg_sel) begin
            nxt_cfg        = reg_req.wdata; // RULE1
            nxt_programmed = 1'b1;
        end
        if (reg_req.rd) begin
            nxt_rdata = cfg_sel ? cfg_ff : `OLRC_RDATA_UNMAPPED; // RULE1
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff        <= `OLRC_CFG_RESET; // RULE1
            rdata_ff      <= `OLRC_RDATA_UNMAPPED;
            rvalid_ff     <= 1'b0;
            programmed_ff <= 1'b0;
        end else begin
            cfg_ff        <= nxt_cfg;
            rdata_ff      <= nxt_rdata;
            rvalid_ff     <= nxt_rvalid;
            programmed_ff <= nxt_programmed;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // ==========================================================
    // Mode decode
    logic outage_mode;
    logic recovery_mode;
    logic flag_drive_cfg;

    assign outage_mode             = cfg_ff.resp_sel[`OLRC_RESP_OUTAGE_BIT]; // RULE4
    assign recovery_mode           = ~outage_mode; // RULE3
    assign flag_drive_cfg          = cfg_ff.resp_sel[`OLRC_RESP_DRIVE_BIT]; // RULE3 RULE4
    assign bus_parity_check_enable = cfg_ff.parity_en; // RULE2

    // ==========================================================
    // Slave address and match
    logic match_ff;
    logic nxt_match;

    assign slave_addr = {`OLRC_ADDR_PREFIX, cfg_ff.bus_addr}; // RULE12 RULE13

    always_comb begin
        nxt_match = addr_probe_valid & (addr_probe == slave_addr); // RULE12
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= nxt_match;
        end
    end

    assign addr_match = match_ff;

    // ==========================================================
    // Fault and flag qualification
    logic flag_drive_ff;
    logic nxt_flag_drive;
    logic any_fault;
    logic fault_seen;
    logic ext_flag;
    logic diag_ff;
    logic nxt_diag;

    assign any_fault = |open_fault;
    // Own drive pulls the line low too, so it is not an outside assertion
    assign ext_flag  = ~fault_flag_line_in & ~flag_drive_ff;
    // Recovery ignores diagnosis results while power good is low
    assign fault_seen = any_fault & (outage_mode | power_good_input); // RULE9 RULE10

    always_comb begin
        nxt_flag_drive = flag_drive_cfg & fault_seen; // RULE14
        nxt_diag       = outage_mode | power_good_input; // RULE5 RULE10
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_drive_ff <= 1'b0;
            diag_ff       <= 1'b0;
        end else begin
            flag_drive_ff <= nxt_flag_drive;
            diag_ff       <= nxt_diag;
        end
    end

    assign fault_flag_line_out  = 1'b0;
    assign fault_flag_line_oe_n = ~flag_drive_ff; // RULE14
    assign diag_active          = diag_ff;

    // ==========================================================
    // Response state machine
    olrc_state_t state_ff;
    olrc_state_t nxt_state;
    olrc_chan_t  chan_ff;
    olrc_chan_t  nxt_chan;
    logic        lp_ff;
    logic        nxt_lp;

    always_comb begin
        nxt_state = state_ff;
        if (!recovery_mode || !power_good_input) begin
            nxt_state = ST_NORMAL; // RULE9 RULE10 RULE11
        end else begin
            unique case (state_ff)
                ST_NORMAL: begin
                    if (ext_flag) begin
                        nxt_state = ST_SHUTDOWN; // RULE8
                    end else if (any_fault) begin
                        nxt_state = ST_RECOVER; // RULE6
                    end
                end
                ST_RECOVER: begin
                    if (ext_flag) begin
                        nxt_state = ST_SHUTDOWN; // RULE8
                    end else if (!any_fault) begin
                        nxt_state = ST_NORMAL; // RULE7
                    end
                end
                ST_SHUTDOWN: begin
                    // A fault still present on release goes straight to recovery
                    if (!ext_flag && any_fault) begin
                        nxt_state = ST_RECOVER; // RULE6
                    end else if (!ext_flag) begin
                        nxt_state = ST_NORMAL; // RULE7
                    end
                end
                default: begin
                    nxt_state = ST_NORMAL;
                end
            endcase
        end
        nxt_lp = (nxt_state == ST_SHUTDOWN); // RULE8
    end

    olrc_chan_gate u_chan_gate (
        .state      (nxt_state),
        .open_fault (open_fault),
        .nxt_chan   (nxt_chan)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_NORMAL;
            chan_ff  <= '{keep: `OLRC_CH_ALL_ON, recovery: `OLRC_CH_ALL_OFF};
            lp_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            chan_ff  <= nxt_chan;
            lp_ff    <= nxt_lp;
        end
    end

    assign chan_ctrl      = chan_ff;
    assign low_power_mode = lp_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_rec_armed;
        recovery_mode && power_good_input && !ext_flag;
    endsequence

    sequence s_rec_fault;
        s_rec_armed ##0 (state_ff == ST_NORMAL) && any_fault;
    endsequence

    sequence s_rec_clear;
        s_rec_armed ##0 (state_ff == ST_RECOVER) && !any_fault;
    endsequence

    a_cfg_write_store: assert property ( // RULE1
        reg_req.wr && cfg_sel |=> cfg_ff == $past(reg_req.wdata))
        else $error("config write not stored");

    a_cfg_read_back: assert property ( // RULE1
        reg_req.rd && cfg_sel |=> reg_rvalid && reg_rdata == $past(cfg_ff))
        else $error("config read wrong");

    a_unmapped_read: assert property ( // RULE1
        reg_req.rd && !cfg_sel |=> reg_rvalid && reg_rdata == `OLRC_RDATA_UNMAPPED)
        else $error("unmapped read not zero");

    a_parity_enable_bit: assert property ( // RULE2
        reg_req.wr && cfg_sel |=> bus_parity_check_enable == $past(reg_req.wdata[7]))
        else $error("parity enable not from bit 7");

    a_flag_undriven_cfg: assert property ( // RULE3
        !$past(flag_drive_cfg) |-> fault_flag_line_oe_n)
        else $error("flag driven in undriven mode");

    a_flag_driven_fault: assert property ( // RULE14
        flag_drive_cfg && any_fault && (outage_mode || power_good_input)
        |=> !fault_flag_line_oe_n)
        else $error("flag not pulled on fault");

    a_diag_pg_gate: assert property ( // RULE5
        recovery_mode && !power_good_input |=> !diag_active)
        else $error("diagnosis active without power good");

    a_rec_keep_faulty: assert property ( // RULE6
        s_rec_fault |=> chan_ctrl.keep == $past(open_fault)
        && chan_ctrl.recovery == $past(open_fault))
        else $error("recovery branch control wrong");

    a_rec_return_normal: assert property ( // RULE7
        s_rec_clear |=> (state_ff == ST_NORMAL) && chan_ctrl.keep == `OLRC_CH_ALL_ON)
        else $error("outputs not restored after fault");

    a_ext_flag_off: assert property ( // RULE8
        recovery_mode && power_good_input && ext_flag
        |=> low_power_mode && chan_ctrl.keep == `OLRC_CH_ALL_OFF)
        else $error("external flag did not shut down");

    a_pg_low_ignore: assert property ( // RULE9
        (recovery_mode && !power_good_input) [*2]
        |-> !low_power_mode && chan_ctrl.keep == `OLRC_CH_ALL_ON)
        else $error("reacted while power good low");

    a_outage_regulate: assert property ( // RULE10
        outage_mode |=> diag_active && chan_ctrl.keep == `OLRC_CH_ALL_ON)
        else $error("outage changed regulation");

    a_outage_no_flag: assert property ( // RULE11
        outage_mode && ext_flag |=> !low_power_mode)
        else $error("outage reacted to external flag");

    a_addr_match: assert property ( // RULE12
        addr_probe_valid && addr_probe == {`OLRC_ADDR_PREFIX, cfg_ff.bus_addr}
        |=> addr_match)
        else $error("own address not matched");

    a_fresh_addr: assert property ( // RULE13
        !programmed_ff |-> slave_addr == `OLRC_FRESH_ADDR)
        else $error("fresh address wrong");

endmodule

// >>> dv/olrc_led_model.sv
// Far-side model: LED strings and the shared wired-OR fault flag line
`timescale 1ns/1ns
`include "olrc_params.svh"

module olrc_led_model (
    // Bench control
    input  wire logic                    ext_pull,
    input  wire logic [`OLRC_NUM_CH-1:0] open_mask,
    // Device side of the flag pin
    input  wire logic                    flag_oe_n,
    input  wire logic                    flag_out,
    output logic                         flag_level,
    // Diagnosis results seen by the device
    output logic [`OLRC_NUM_CH-1:0]      open_fault
);
    // ==========================================================
    // Pull-up holds the line high unless some party sinks it
    assign flag_level = (ext_pull || (!flag_oe_n && !flag_out)) ? 1'b0 : 1'b1;
    // A broken string reports open on its channel
    assign open_fault = open_mask;
endmodule

// >>> dv/open_load_response_config_bench.sv
// Self-checking bench of the open-load response configuration block
`timescale 1ns/1ns
`include "olrc_params.svh"

module open_load_response_config_bench
    import olrc_pkg::*;
;
    // ==========================================================
    // Signals
    logic          sys_clk;
    logic          rst_n;
    olrc_reg_req_t reg_req;
    logic [7:0]    reg_rdata;
    logic          reg_rvalid;
    logic          reg_hit;
    logic [6:0]    addr_probe;
    logic          addr_probe_valid;
    logic [6:0]    slave_addr;
    logic          addr_match;
    logic          bus_parity_check_enable;
    logic          pg;
    logic [11:0]   open_mask;
    logic [11:0]   open_fault;
    logic          diag_active;
    logic          flag_level;
    logic          flag_out;
    logic          flag_oe_n;
    logic          ext_pull;
    olrc_chan_t    chan_ctrl;
    logic          low_power_mode;
    int            n_errors;
    int            comparisons;
    int            cycles = 0;
    int            cfg;
    int            e_oe;
    logic [31:0]   seed;
    logic [13:0]   steps_tab [10] = '{14'h2001, 14'h2001, 14'h2000, 14'h2800, 14'h2fff,
                                      14'h3000, 14'h3000, 14'h2000, 14'h10f0, 14'h2000};
    logic [7:0]    cfg_tab [4] = '{8'h15, 8'hab, 8'h4a, 8'he1};

    olrc_top u_dut (
        .sys_clk                 (sys_clk),
        .rst_n                   (rst_n),
        .reg_req                 (reg_req),
        .reg_rdata               (reg_rdata),
        .reg_rvalid              (reg_rvalid),
        .reg_hit                 (reg_hit),
        .addr_probe              (addr_probe),
        .addr_probe_valid        (addr_probe_valid),
        .slave_addr              (slave_addr),
        .addr_match              (addr_match),
        .bus_parity_check_enable (bus_parity_check_enable),
        .power_good_input        (pg),
        .open_fault              (open_fault),
        .diag_active             (diag_active),
        .fault_flag_line_in      (flag_level),
        .fault_flag_line_out     (flag_out),
        .fault_flag_line_oe_n    (flag_oe_n),
        .chan_ctrl               (chan_ctrl),
        .low_power_mode          (low_power_mode)
    );

    olrc_led_model u_leds (
        .ext_pull   (ext_pull),
        .open_mask  (open_mask),
        .flag_oe_n  (flag_oe_n),
        .flag_out   (flag_out),
        .flag_level (flag_level),
        .open_fault (open_fault)
    );

    always #25 sys_clk = ~sys_clk;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expd);
        comparisons++;
        if (seen !== expd) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, expd, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        #1 check("hit_wr", reg_hit, a == `OLRC_CFG_OFFSET);
        @(negedge sys_clk);
        reg_req.wr = 1'b0;
        if (a == `OLRC_CFG_OFFSET) cfg = d;
        check("slave_addr", slave_addr, {2'b01, cfg[4:0]});
        check("parity_en", bus_parity_check_enable, cfg[7]);
        @(negedge sys_clk);
    endtask

    task automatic reg_read(input logic [7:0] a);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        #1 check("hit_rd", reg_hit, a == `OLRC_CFG_OFFSET);
        @(negedge sys_clk);
        reg_req.rd = 1'b0;
        check("rvalid", reg_rvalid, 1'b1);
        check("rdata", reg_rdata, (a == `OLRC_CFG_OFFSET) ? cfg[7:0] : `OLRC_RDATA_UNMAPPED);
        @(negedge sys_clk);
    endtask

    task automatic probe(input logic [6:0] a);
        addr_probe = a;
        addr_probe_valid = 1'b1;
        @(negedge sys_clk);
        addr_probe_valid = 1'b0;
        check("addr_match", addr_match, a == {2'b01, cfg[4:0]});
        @(negedge sys_clk);
    endtask

    // One cycle of diagnosis traffic against the reference model
    task automatic step(input logic p, input logic [11:0] f, input logic x);
        int outage;
        int keep;
        int rec;
        int lp;
        int oe;
        outage = cfg[6];
        pg = p;
        open_mask = f;
        ext_pull = x;
        @(negedge sys_clk);
        keep = 'hfff;
        rec = 0;
        lp = 0;
        oe = 1;
        if (outage) begin
            oe = !(cfg[5] && f != 0);
        end else if (p && x && e_oe) begin
            keep = 0;
            lp = 1;
        end else if (p && f != 0) begin
            keep = f;
            rec = f;
            oe = !cfg[5];
        end
        e_oe = oe;
        check("keep", chan_ctrl.keep, keep[15:0]);
        check("recovery", chan_ctrl.recovery, rec[15:0]);
        check("low_power", low_power_mode, lp[0]);
        check("flag_oe_n", flag_oe_n, oe[0]);
        check("flag_out", flag_out, 1'b0);
        check("diag", diag_active, outage[0] | p);
    endtask

    // ==========================================================
    // Timeout
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [11:0] rf;
        logic        rx;
        sys_clk = 1'b0;
        rst_n = 1'b0;
        reg_req = '0;
        addr_probe = 7'h00;
        addr_probe_valid = 1'b0;
        pg = 1'b0;
        open_mask = 12'h000;
        ext_pull = 1'b0;
        cfg = 0;
        e_oe = 1;
        n_errors = 0;
        comparisons = 0;
        seed = 32'h73b6_7b27;
        repeat (6) @(negedge sys_clk);
        check("keep_rst", chan_ctrl.keep, `OLRC_CH_ALL_ON);
        check("oe_rst", flag_oe_n, 1'b1);
        check("addr_rst", slave_addr, `OLRC_FRESH_ADDR);
        rst_n = 1'b1;
        reg_read(`OLRC_CFG_OFFSET);
        probe(`OLRC_FRESH_ADDR);
        probe(7'h21);
        reg_write(8'h24, 8'hff);
        reg_read(8'h24);
        reg_read(`OLRC_CFG_OFFSET);
        for (int m = 0; m < 4; m++) begin
            step(1'b1, 12'h000, 1'b0);
            reg_write(`OLRC_CFG_OFFSET, cfg_tab[m]);
            reg_read(`OLRC_CFG_OFFSET);
            probe({2'b01, cfg_tab[m][4:0]});
            probe(7'h20);
            for (int s = 0; s < 10; s++) begin
                step(steps_tab[s][13], steps_tab[s][11:0], steps_tab[s][12]);
            end
        end
        for (int k = 0; k < 300; k++) begin
            seed = lfsr(seed);
            if (k % 25 == 0) begin
                step(1'b1, 12'h000, 1'b0);
                reg_write(`OLRC_CFG_OFFSET, seed[15:8] | 8'h01);
                probe({2'b01, cfg[4:0]});
            end
            rx = seed[2] & seed[9];
            rf = rx ? 12'h000 : (seed[27:16] & seed[14:3]);
            step(seed[0] | seed[1], rf, rx);
        end
        end_of_test();
    end
endmodule
